// ### hw/vbc_berr_capture.sv
`timescale 1ns/1ns
`include "vbc_params.svh"
// Contract
// - the auxiliary timeout timer runs only while command bit 3 is set.
// - bits 5 and 4 of the command register select one of four periods, bit 5 high.
// - periods count pci clocks, roughly 16, 64, 256 us and 1 ms at the 10 ns clock the defaults assume.
// - capture works only while command bit 2 is set.
// - address and modifier of a board-mastered transfer ended by berr are latched.
// - captured address reads at 0xD8010, modifier in bits 5..0 at 0xD8014.
// - a captured berr sets the error flag at command bit 7.
// - while the flag is set the captured values stay frozen.
// - writing one to the flag clears it, writing zero leaves it.
// - with bit 6, capture and the mask bit at 0xD8018 enabled a captured berr raises the interrupt.
// - the interrupt stays until the flag, bit 6, bit 2 or the mask bit is cleared, and drops with it.
// - control and status bits live in one byte register at 0xD800E, except the interrupt mask bit at 0xD8018.
module vbc_berr_capture
	import vbc_pkg::*;
#(
	parameter int unsigned T0_CYC = (`VBC_T0_NS + `VBC_CLK_NS - 1) / `VBC_CLK_NS,
	parameter int unsigned T1_CYC = (`VBC_T1_NS + `VBC_CLK_NS - 1) / `VBC_CLK_NS,
	parameter int unsigned T2_CYC = (`VBC_T2_NS + `VBC_CLK_NS - 1) / `VBC_CLK_NS,
	parameter int unsigned T3_CYC = (`VBC_T3_NS + `VBC_CLK_NS - 1) / `VBC_CLK_NS
)
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [19:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic irq_out,
	input wire logic master_in,
	input wire logic ds_in,
	input wire logic dtack_in,
	input wire logic berr_in,
	input wire logic [31:0] vme_addr_in,
	input wire logic [5:0] vme_am_in,
	output logic berr_drv_out
);
	import vbc_pkg::*;

	vbc_state_s cur_reg, cur_next;

	// ========================================
	// period decode
	function automatic logic [19:0] period_cycles(input logic [1:0] sel);
		logic [19:0] p;
		p = 20'h00000;
		case (sel)
			2'h0: p = T0_CYC[19:0];
			2'h1: p = T1_CYC[19:0];
			2'h2: p = T2_CYC[19:0];
			default: p = T3_CYC[19:0];
		endcase
		return p;
	endfunction

	// agreed level once stages two and three match
	function automatic logic agreed(input logic [2:0] s, input logic prev);
		logic r;
		r = prev;
		if (s[2] == s[1])
			r = s[1];
		return r;
	endfunction

	// register address match, shared by write and read decode
	function automatic logic hit(input logic [19:0] a, input logic [19:0] off);
		logic r;
		r = (a == off);
		return r;
	endfunction

	logic [1:0] sel;
	logic set_flag;
	logic clr_flag;
	logic expire;
	logic berr_rise;
	logic wr_cmd;
	logic wr_mask;
	assign sel = {cur_reg.cmd[`VBC_BIT_SEL_HI], cur_reg.cmd[`VBC_BIT_SEL_LO]};
	// bus strobes come from the same clock, so they are decoded without synchronisers
	assign wr_cmd = wr_in && hit(addr_in, `VBC_OFF_CMD);
	assign wr_mask = wr_in && hit(addr_in, `VBC_OFF_MASK);

	// ========================================
	// next state
	always_comb
	begin
		cur_next = cur_reg;
		// three-stage synchronisers for the asynchronous bus levels
		cur_next.ds_sync = {cur_reg.ds_sync[1:0], ds_in};
		cur_next.ack_sync = {cur_reg.ack_sync[1:0], dtack_in};
		cur_next.berr_sync = {cur_reg.berr_sync[1:0], berr_in};
		cur_next.ds_q = agreed(cur_reg.ds_sync, cur_reg.ds_q);
		cur_next.ack_q = agreed(cur_reg.ack_sync, cur_reg.ack_q);
		cur_next.berr_q = agreed(cur_reg.berr_sync, cur_reg.berr_q);
		// edge of the agreed level, so a long berr captures only once
		berr_rise = cur_next.berr_q && !cur_reg.berr_q;
		cur_next.rdata = 32'h00000000;
		expire = 1'b0;
		// timer: idle -> counting on own strobe -> waits for strobe release
		case (cur_reg.state)
			VBC_IDLE:
			begin
				cur_next.cnt = 20'h00000;
				cur_next.berr_drv = 1'b0;
				if (cur_reg.cmd[`VBC_BIT_TMR_EN] && master_in && cur_reg.ds_q)
					cur_next.state = VBC_WAIT;
			end
			VBC_WAIT:
			begin
				cur_next.cnt = cur_reg.cnt + 20'h00001;
				if (!cur_reg.cmd[`VBC_BIT_TMR_EN] || !cur_reg.ds_q || cur_reg.ack_q
					|| cur_reg.berr_q)
					cur_next.state = VBC_IDLE;
				else if (cur_reg.cnt + 20'h00001 >= period_cycles(sel))
				begin
					expire = 1'b1;
					cur_next.berr_drv = 1'b1;
					cur_next.state = VBC_DONE;
				end
			end
			default:
			begin
				// hold berr until the strobe is withdrawn
				if (!cur_reg.ds_q)
				begin
					cur_next.berr_drv = 1'b0;
					cur_next.state = VBC_IDLE;
				end
			end
		endcase
		// capture on external or own berr; frozen while flag set
		// limitation: master_in is taken when the synchronised edge arrives, some
		// cycles after the pin moved, so the board must keep it until then
		set_flag = cur_reg.cmd[`VBC_BIT_CAP_EN] && master_in
			&& (berr_rise || expire);
		clr_flag = wr_cmd && wdata_in[`VBC_BIT_FLAG];
		if (set_flag && !cur_reg.cmd[`VBC_BIT_FLAG])
		begin
			cur_next.cap_addr = vme_addr_in;
			cur_next.cap_am = vme_am_in;
		end
		// register writes; set beats clear in the same cycle so no event is lost
		if (wr_cmd)
			cur_next.cmd[`VBC_BIT_FLAG - 1:0] = wdata_in[`VBC_BIT_FLAG - 1:0];
		else if (wr_mask)
			cur_next.mask = wdata_in[0];
		if (set_flag)
			cur_next.cmd[`VBC_BIT_FLAG] = 1'b1;
		else if (clr_flag)
			cur_next.cmd[`VBC_BIT_FLAG] = 1'b0;
		// reads, data valid the cycle after and zero otherwise
		if (rd_in)
		begin
			if (hit(addr_in, `VBC_OFF_CMD))
				cur_next.rdata = {24'h000000, cur_reg.cmd};
			else if (hit(addr_in, `VBC_OFF_ADDR))
				cur_next.rdata = cur_reg.cap_addr;
			else if (hit(addr_in, `VBC_OFF_AM))
				cur_next.rdata = {26'h0000000, cur_reg.cap_am};
			else if (hit(addr_in, `VBC_OFF_MASK))
				cur_next.rdata = {31'h00000000, cur_reg.mask};
			else
				cur_next.rdata = 32'h00000000;
		end
		// irq follows the flag, gated by enable and mask
		cur_next.irq = cur_next.cmd[`VBC_BIT_FLAG] && cur_next.cmd[`VBC_BIT_IRQ_EN]
			&& cur_next.cmd[`VBC_BIT_CAP_EN] && cur_next.mask;
	end

	// ========================================
	// state register
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			cur_reg <= '0;
			cur_reg.mask <= `VBC_MASK_RESET;
			cur_reg.state <= VBC_IDLE;
		end
		else
			cur_reg <= cur_next;
	end

	assign rdata_out = cur_reg.rdata;
	assign irq_out = cur_reg.irq;
	assign berr_drv_out = cur_reg.berr_drv;

	// ========================================
	// checks: error flag

	// a capture event always leaves the flag set
	flag_sets_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		set_flag |=> cur_reg.cmd[`VBC_BIT_FLAG])
		else $error("flag not set by capture");

	// a one written to the flag clears it when no event competes
	flag_clears_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		clr_flag && !set_flag |=> !cur_reg.cmd[`VBC_BIT_FLAG])
		else $error("flag not cleared by one");

	// a zero written back leaves a set flag alone
	zero_keeps_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.cmd[`VBC_BIT_FLAG] && !clr_flag |=> cur_reg.cmd[`VBC_BIT_FLAG])
		else $error("flag lost without clear");

	// the event wins over a clear in the same cycle
	set_wins_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		set_flag && clr_flag |=> cur_reg.cmd[`VBC_BIT_FLAG])
		else $error("clear beat a capture");

	// ========================================
	// checks: capture

	// the captured address does not move while the flag is up
	frozen_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.cmd[`VBC_BIT_FLAG] |=> $stable(cur_reg.cap_addr))
		else $error("capture changed while frozen");

	// the captured modifier is frozen the same way
	frozen_am_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.cmd[`VBC_BIT_FLAG] |=> $stable(cur_reg.cap_am))
		else $error("modifier changed while frozen");

	// a first event latches the bus address and modifier of that cycle
	cap_latch_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		set_flag && !cur_reg.cmd[`VBC_BIT_FLAG] |=> cur_reg.cap_addr == $past(vme_addr_in)
		&& cur_reg.cap_am == $past(vme_am_in))
		else $error("capture did not latch");

	// nothing is captured while the logic is disabled
	no_cap_off_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!cur_reg.cmd[`VBC_BIT_CAP_EN] |-> !set_flag)
		else $error("capture while disabled");

	// transfers mastered by another board are ignored
	no_master_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!master_in |-> !set_flag)
		else $error("capture without mastership");

	// ========================================
	// checks: interrupt

	// the interrupt needs the flag and its enable
	irq_follows_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		irq_out |-> cur_reg.cmd[`VBC_BIT_FLAG] && cur_reg.cmd[`VBC_BIT_IRQ_EN])
		else $error("irq without flag");

	// all gates open means the interrupt is up
	irq_raise_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.cmd[`VBC_BIT_FLAG] && cur_reg.cmd[`VBC_BIT_IRQ_EN]
		&& cur_reg.cmd[`VBC_BIT_CAP_EN] && cur_reg.mask |-> irq_out)
		else $error("irq missing");

	// capture disabled keeps the interrupt quiet
	irq_needs_cap_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!cur_reg.cmd[`VBC_BIT_CAP_EN] |-> !irq_out)
		else $error("irq while capture off");

	// the extra mask bit gates the line
	irq_masked_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!cur_reg.mask |-> !irq_out)
		else $error("irq while masked");

	// clearing the flag drops the line in the same cycle
	irq_drops_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		$fell(cur_reg.cmd[`VBC_BIT_FLAG]) |-> !irq_out)
		else $error("irq held after clear");

	// ========================================
	// checks: timeout timer

	// a disabled timer never starts
	timer_off_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!cur_reg.cmd[`VBC_BIT_TMR_EN] |=> cur_reg.state != VBC_WAIT
		|| $past(cur_reg.state) != VBC_IDLE)
		else $error("timer started while off");

	// turning the timer off abandons a running count
	timer_stop_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_WAIT && !cur_reg.cmd[`VBC_BIT_TMR_EN] |=> cur_reg.state == VBC_IDLE)
		else $error("timer ran while off");

	// an own strobe with the timer on starts the count
	wait_enter_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_IDLE && cur_reg.cmd[`VBC_BIT_TMR_EN] && master_in
		&& cur_reg.ds_q |=> cur_reg.state == VBC_WAIT)
		else $error("timer did not start");

	// the count starts from zero
	idle_zero_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_IDLE |=> cur_reg.cnt == 20'h00000)
		else $error("count not cleared");

	// the count steps by one pci clock while waiting
	count_step_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_WAIT |=> cur_reg.state != VBC_WAIT
		|| cur_reg.cnt == $past(cur_reg.cnt) + 20'h00001)
		else $error("count skipped");

	// expiry comes at the selected period and drives berr next
	expiry_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		expire |-> cur_reg.cnt + 20'h00001 >= period_cycles(sel) ##1 berr_drv_out)
		else $error("berr not driven on expiry");

	// an acknowledge ends the count without berr
	ack_stops_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_WAIT && cur_reg.ack_q |=> cur_reg.state == VBC_IDLE
		&& !berr_drv_out)
		else $error("ack did not stop timer");

	// a berr from elsewhere also ends the count
	berr_stops_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_WAIT && cur_reg.berr_q |=> cur_reg.state == VBC_IDLE)
		else $error("berr did not stop timer");

	// own berr stands while the strobe stays
	berr_hold_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_DONE && cur_reg.ds_q |=> berr_drv_out)
		else $error("berr dropped early");

	// own berr is released with the strobe
	done_release_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.state == VBC_DONE && !cur_reg.ds_q |=> cur_reg.state == VBC_IDLE
		&& !berr_drv_out)
		else $error("berr not released");

	// own berr only after an expiry
	berr_only_done_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		berr_drv_out |-> cur_reg.state == VBC_DONE)
		else $error("berr outside timeout");

	// ========================================
	// checks: register port and strobe synchroniser

	// read data is zero outside the answer cycle
	rdata_idle_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		!rd_in |=> rdata_out == 32'h00000000)
		else $error("read data outside answer");

	// command byte reads back in the low byte
	read_cmd_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		rd_in && hit(addr_in, `VBC_OFF_CMD) |=> rdata_out == {24'h000000, $past(cur_reg.cmd)})
		else $error("command read wrong");

	// captured address reads as a whole longword
	read_addr_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		rd_in && hit(addr_in, `VBC_OFF_ADDR) |=> rdata_out == $past(cur_reg.cap_addr))
		else $error("address read wrong");

	// modifier reads in the low six bits, the rest zero
	read_am_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		rd_in && hit(addr_in, `VBC_OFF_AM) |=> rdata_out == {26'h0000000, $past(cur_reg.cap_am)})
		else $error("modifier read wrong");

	// control bits follow a command write
	cmd_write_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		wr_cmd |=> cur_reg.cmd[`VBC_BIT_FLAG - 1:0] == $past(wdata_in[`VBC_BIT_FLAG - 1:0]))
		else $error("command write lost");

	// mask bit follows its write
	mask_write_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		wr_mask |=> cur_reg.mask == $past(wdata_in[0]))
		else $error("mask write lost");

	// the strobe level moves only once two stages agree
	sync_agree_a: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
		cur_reg.ds_sync[2] == cur_reg.ds_sync[1] |=> cur_reg.ds_q == $past(cur_reg.ds_sync[1]))
		else $error("strobe sync wrong");
endmodule

// ### hw/vbc_params.svh
`ifndef VBC_PARAMS_SVH
`define VBC_PARAMS_SVH
// ========================================
// register map (byte addresses, low 20 bits)
`define VBC_ADDR_W 20
`define VBC_OFF_CMD 20'hD800E
`define VBC_OFF_ADDR 20'hD8010
`define VBC_OFF_AM 20'hD8014
`define VBC_OFF_MASK 20'hD8018
// ========================================
// command/status fields
`define VBC_BIT_CAP_EN 2
`define VBC_BIT_TMR_EN 3
`define VBC_BIT_SEL_LO 4
`define VBC_BIT_SEL_HI 5
`define VBC_BIT_IRQ_EN 6
`define VBC_BIT_FLAG 7
`define VBC_CMD_RESET 8'h00
`define VBC_MASK_RESET 1'b1
`define VBC_AM_W 6
// ========================================
// timeout periods in ns, converted to cycles of a 10 ns pci clock
`define VBC_T0_NS 16000
`define VBC_T1_NS 64000
`define VBC_T2_NS 256000
`define VBC_T3_NS 1000000
`define VBC_CLK_NS 10
`endif

// ### hw/vbc_pkg.sv
package vbc_pkg;
	typedef enum logic [1:0] {VBC_IDLE, VBC_WAIT, VBC_DONE} vbc_state_e;
	typedef struct packed {
		vbc_state_e state;
		logic [7:0] cmd;
		logic [31:0] cap_addr;
		logic [5:0] cap_am;
		logic [31:0] rdata;
		logic [19:0] cnt;
		logic berr_drv;
		logic irq;
		logic mask;
		logic [2:0] ds_sync;
		logic [2:0] ack_sync;
		logic [2:0] berr_sync;
		logic ds_q;
		logic ack_q;
		logic berr_q;
	} vbc_state_s;
endpackage

// ### bench/vbc_vme_slave.sv
`timescale 1ns/1ns
// ========================================
// far-side slave: answers a board strobe after lat cycles
module vbc_vme_slave
(
	input wire logic clk_in,
	input wire logic ds_in,
	input wire logic [1:0] mode_in,
	input wire logic [3:0] lat_in,
	output logic dtack_out,
	output logic berr_out
);
	logic [3:0] cnt_reg;
	// mode 0 never answers, so only the board timer or the lim cut in xfer can end the cycle
	always_ff @(posedge clk_in)
	begin
		cnt_reg <= ds_in ? cnt_reg + 4'h1 : 4'h0;
		dtack_out <= ds_in && mode_in == 2'h1 && cnt_reg >= lat_in;
		berr_out <= ds_in && mode_in == 2'h2 && cnt_reg >= lat_in;
	end
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ns
`include "vbc_params.svh"
module testbench;
	localparam int TC[4] = '{8, 32, 128, 512};
	logic clk = 0, rstn = 0, wr = 0, rd = 0, m = 0, ds = 0;
	logic [19:0] a = '0;
	logic [31:0] wd = '0, rdata, va = '0, v;
	logic [5:0] am = '0;
	logic [1:0] mode = '0;
	logic [3:0] lat = '0;
	logic irq, bdrv, dtack, berr;
	int fail_count = 0, tests_run = 0, n;
	// ========================================
	// clock and units
	always #5 clk = ~clk;
	vbc_berr_capture #(.T0_CYC(TC[0]), .T1_CYC(TC[1]), .T2_CYC(TC[2]), .T3_CYC(TC[3])) uut
	(.ref_clk_in(clk), .resetn_in(rstn), .addr_in(a), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
	.rdata_out(rdata), .irq_out(irq), .master_in(m), .ds_in(ds), .dtack_in(dtack),
	.berr_in(berr), .vme_addr_in(va), .vme_am_in(am), .berr_drv_out(bdrv));
	vbc_vme_slave slv (.clk_in(clk), .ds_in(ds), .mode_in(mode), .lat_in(lat),
	.dtack_out(dtack), .berr_out(berr));
	// ========================================
	// tasks
	task stop_test;
		$display("checks %0d errors %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wrr(input logic [19:0] ad, input logic [31:0] d);
		@(posedge clk);
		a <= ad;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task rdr(input logic [19:0] ad, output logic [31:0] d);
		@(posedge clk);
		a <= ad;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask
	// one board transfer; a hung cycle is cut at lim cycles
	task xfer(input logic mst, input logic [1:0] md, input logic [31:0] x, input logic [5:0] y,
		input int lim);
		@(posedge clk);
		m <= mst;
		mode <= md;
		lat <= 4'h3;
		va <= x;
		am <= y;
		ds <= 1;
		n = 0;
		while (!(dtack || berr || bdrv) && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= lim && md != 2'h0)
		begin
			fail_count++;
			stop_test;
		end
		@(posedge clk);
		ds <= 0;
		repeat (10) @(posedge clk);
		m <= 0;
	endtask
	// ========================================
	// sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		rdr(`VBC_OFF_CMD, v); chk(v, 32'h00);
		rdr(20'hD8020, v); chk(v, 32'h00);
		wrr(`VBC_OFF_CMD, 32'h44);
		xfer(1, 2'h2, 32'h1234_5678, 6'h2A, 50);
		rdr(`VBC_OFF_CMD, v); chk(v, 32'hC4);
		chk(irq, 1);
		rdr(`VBC_OFF_ADDR, v); chk(v, 32'h1234_5678);
		rdr(`VBC_OFF_AM, v); chk(v, 32'h2A);
		xfer(1, 2'h2, 32'h0BAD_0000, 6'h15, 50);
		rdr(`VBC_OFF_ADDR, v); chk(v, 32'h1234_5678);
		rdr(`VBC_OFF_AM, v); chk(v, 32'h2A);
		wrr(`VBC_OFF_MASK, 32'h0); chk(irq, 0);
		wrr(`VBC_OFF_MASK, 32'h1); chk(irq, 1);
		wrr(`VBC_OFF_CMD, 32'h44); chk(irq, 1);
		rdr(`VBC_OFF_CMD, v); chk(v, 32'hC4);
		wrr(`VBC_OFF_CMD, 32'hC4); chk(irq, 0);
		rdr(`VBC_OFF_CMD, v); chk(v, 32'h44);
		xfer(0, 2'h2, 32'h0000_00AA, 6'h01, 50);
		rdr(`VBC_OFF_CMD, v); chk(v, 32'h44);
		wrr(`VBC_OFF_CMD, 32'h40);
		xfer(1, 2'h2, 32'h0000_00BB, 6'h02, 50);
		rdr(`VBC_OFF_CMD, v); chk(v, 32'h40);
		chk(irq, 0);
		// timer alone, capture off; no second timeout source exists here
		for (int s = 0; s < 4; s++)
		begin
			wrr(`VBC_OFF_CMD, 32'h08 | (s << 4));
			xfer(1, 2'h0, 32'h0, 6'h0, 700);
			chk(n >= TC[s] && n <= TC[s] + 10, 1);
			chk(bdrv, 0);
		end
		xfer(1, 2'h1, 32'h0, 6'h0, 50);
		chk(n < 10, 1);
		wrr(`VBC_OFF_CMD, 32'h00);
		xfer(1, 2'h0, 32'h0, 6'h0, 100);
		chk(n, 100);
		stop_test;
	end
endmodule
